//--- rtl/ulcd_defines.vh
// constants for the usb line coding and attach detect block
// assumes one core clock of 200 MHz and an axi4-lite bus master
`ifndef ULCD_DEFINES_VH
`define ULCD_DEFINES_VH
// clock and line rates
`define ULCD_CLK_MHZ 8'hc8
`define ULCD_ENG_MHZ 8'h30
`define ULCD_CLK_KHZ 200000
`define ULCD_IDLE_MS 3
`define ULCD_IDLE_CYCLES (`ULCD_IDLE_MS * `ULCD_CLK_KHZ)
// register byte offsets
`define ULCD_A_CTRL 8'h00
`define ULCD_A_CFG 8'h04
`define ULCD_A_STAT 8'h08
`define ULCD_A_ADDR 8'h0c
`define ULCD_A_FRML 8'h10
`define ULCD_A_FRMH 8'h14
`define ULCD_A_IFLG 8'h18
`define ULCD_A_IEN 8'h1c
`define ULCD_A_EFLG 8'h20
`define ULCD_A_EEN 8'h24
`define ULCD_A_EP0 8'h28
`define ULCD_A_EP7 8'h44
`define ULCD_A_TXD 8'h48
`define ULCD_A_TXCMD 8'h4c
`define ULCD_A_RXD 8'h50
`define ULCD_A_LINE 8'h54
// field positions and writable masks
`define ULCD_B_EN 3
`define ULCD_B_SOF 6
`define ULCD_B_IDLE 4
`define ULCD_B_TRN 3
`define ULCD_B_ACTV 2
`define ULCD_B_UERR 1
`define ULCD_B_STUFF 7
`define ULCD_B_DFN8 3
`define ULCD_B_CRC16 2
`define ULCD_M_CTRL 8'h7e
`define ULCD_M_CFG 8'h97
`define ULCD_M_ADDR 8'h7f
`define ULCD_M_IEN 8'h7f
`define ULCD_M_EEN 8'h9f
`define ULCD_M_EP 8'h1f
`define ULCD_M_IFLG 8'h5c
`define ULCD_M_EFLG 8'h8c
// packet constants
`define ULCD_SYNC 8'h80
`define ULCD_PID_SOF 8'ha5
`define ULCD_CRC_INIT 16'hffff
`define ULCD_CRC_POLY 16'h8005
`define ULCD_CRC_RES 16'h800d
`define ULCD_RESP_OK 2'h0
`define ULCD_RESP_ERR 2'h2
`endif

//--- rtl/ulcd_top.v
// usb full-speed line coding engine with attach detect and axi4-lite regs
// assumes a synchronous aclk, external transceiver pins split in/out/oe
//
// Behaviour
// - each zero bit sent or received toggles the line between j and k
// - a one bit leaves the line unchanged, stuffed bits excepted
// - stuff bits are added on transmit and dropped on receive by hardware
// - nrzi coding plus crc16 generation and checking are done in hardware
// - device drives the cable only while sending; otherwise it just listens
// - the engine paces bits from a 48 MHz rate, four ticks per bit
// - engine rate is separate from the core clock rate
// - changes on either data line are sensed to detect attachment
// - change sensing works only while the module enable bit is clear
// - setting the module enable bit turns change sensing off by itself
// - over 3 ms without bus traffic sets the idle detect flag
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "ulcd_defines.vh"

// byte fifo between the register bus and the transmitter
module ulcd_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire aclk,
	input wire aresetn,
	input wire [WIDTH-1:0] s_data,
	input wire s_valid,
	output wire s_ready,
	output wire [WIDTH-1:0] m_data,
	output wire m_valid,
	input wire m_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wp;
	reg [AW:0] rp;
	wire full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
	wire empty = (wp == rp);
	assign s_ready = ~full;
	assign m_valid = ~empty;
	assign m_data = mem[rp[AW-1:0]];
	// pointers carry one extra wrap bit so full and empty differ
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wp <= {(AW+1){1'b0}};
			rp <= {(AW+1){1'b0}};
		end
		else
		begin
			if (s_valid && !full)
			begin
				mem[wp[AW-1:0]] <= s_data;
				wp <= wp + 1'b1;
			end
			if (m_ready && !empty)
				rp <= rp + 1'b1;
		end
	end
endmodule // ulcd_fifo

module ulcd_top #(
	parameter IDLE_CYCLES = `ULCD_IDLE_CYCLES
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire dp_in,
	output wire dp_out,
	output wire dp_oe,
	input wire dm_in,
	output wire dm_out,
	output wire dm_oe
);
	localparam TX_IDLE = 2'h0;
	localparam TX_BITS = 2'h1;
	localparam TX_CRC = 2'h2;
	localparam TX_EOP = 2'h3;
	localparam RX_HUNT = 2'h0;
	localparam RX_DATA = 2'h1;
	localparam RX_WAIT = 2'h2;

	reg [7:0] usb_control, usb_configuration, transfer_status;
	reg [7:0] device_address, frame_number_low, frame_number_high;
	reg [7:0] usb_interrupt_flags, usb_interrupt_enables;
	reg [7:0] usb_error_flags, usb_error_enables, rx_data;
	reg [7:0] ep_ctrl [0:7];
	reg attach_flag;
	wire module_enable_bit = usb_control[`ULCD_B_EN];

	// engine tick at 48 MHz by fractional accumulation, bit tick every 4
	reg [7:0] acc;
	reg [1:0] tick_cnt;
	reg bit_en;
	wire [8:0] acc_sum = {1'b0, acc} + {1'b0, `ULCD_ENG_MHZ};
	wire eng_en = (acc_sum >= {1'b0, `ULCD_CLK_MHZ});
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			acc <= 8'h00;
			tick_cnt <= 2'h0;
			bit_en <= 1'b0;
		end
		else
		begin
			acc <= eng_en ? acc_sum[7:0] - `ULCD_CLK_MHZ : acc_sum[7:0];
			if (eng_en)
				tick_cnt <= tick_cnt + 2'h1;
			bit_en <= eng_en && (tick_cnt == 2'h3);
		end
	end

	// pin synchronisers; level moves once stages two and three agree
	reg [2:0] dp_sy, dm_sy;
	reg dp_l, dm_l, dp_prev, dm_prev;
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			// detached lines rest high on pull-ups; no false edge
			dp_sy <= 3'h7;
			dm_sy <= 3'h7;
			dp_l <= 1'b1;
			dm_l <= 1'b1;
			dp_prev <= 1'b1;
			dm_prev <= 1'b1;
		end
		else
		begin
			dp_sy <= {dp_sy[1:0], dp_in};
			dm_sy <= {dm_sy[1:0], dm_in};
			if (dp_sy[1] == dp_sy[2])
				dp_l <= dp_sy[2];
			if (dm_sy[1] == dm_sy[2])
				dm_l <= dm_sy[2];
			dp_prev <= dp_l;
			dm_prev <= dm_l;
		end
	end
	wire line_j = dp_l & ~dm_l;
	wire line_se0 = ~dp_l & ~dm_l;
	// attach sensing is gated by the enable bit, no firmware step needed
	wire attach_set = ~module_enable_bit &
		((dp_l != dp_prev) | (dm_l != dm_prev));

	// bus write side; tx data writes stall while the fifo is full
	wire wr_txd = (s_axi_awaddr == `ULCD_A_TXD);
	wire fifo_s_ready;
	wire wr_fire = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid &
		~(wr_txd & ~fifo_s_ready);
	assign s_axi_awready = wr_fire;
	assign s_axi_wready = wr_fire;
	wire wr_en = wr_fire & s_axi_wstrb[0];
	wire [7:0] wd = s_axi_wdata[7:0];
	wire [7:0] fifo_m_data;
	wire fifo_m_valid;
	reg fifo_pop;
	ulcd_fifo #(.WIDTH(8), .DEPTH(16), .AW(4)) i_ulcd_fifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_data(wd),
		.s_valid(wr_en & wr_txd),
		.s_ready(fifo_s_ready),
		.m_data(fifo_m_data),
		.m_valid(fifo_m_valid),
		.m_ready(fifo_pop)
	);
	function wr_at;
		input [7:0] a;
		begin
			wr_at = wr_en && (s_axi_awaddr == a);
		end
	endfunction
	wire wr_ep = wr_en && (s_axi_awaddr >= `ULCD_A_EP0) &&
		(s_axi_awaddr <= `ULCD_A_EP7) && (s_axi_awaddr[1:0] == 2'h0);
	wire [7:0] ep_off = s_axi_awaddr - `ULCD_A_EP0;
	wire map_w = (s_axi_awaddr <= `ULCD_A_LINE) &&
		(s_axi_awaddr[1:0] == 2'h0);

	// transmitter state
	reg [1:0] tx_st;
	reg [7:0] tx_sr;
	reg [3:0] tx_cnt;
	reg [2:0] tx_ones;
	reg [1:0] tx_bytes;
	reg [15:0] tx_crc;
	reg tx_crc_on, tx_level, tx_se0, tx_oe;
	reg tx_done;
	wire tx_start = wr_at(`ULCD_A_TXCMD) & wd[0] & (tx_st == TX_IDLE) &
		fifo_m_valid & module_enable_bit;
	wire tx_bit = (tx_st == TX_CRC) ? ~tx_crc[15] : tx_sr[0];
	wire tx_stuff = (tx_ones == 3'h6);
	wire tx_fb = tx_crc[15] ^ tx_bit;
	// line is driven only while this end sends
	assign dp_oe = tx_oe;
	assign dm_oe = tx_oe;
	assign dp_out = ~tx_se0 & tx_level;
	assign dm_out = ~tx_se0 & ~tx_level;

	// fifo pops at the last bit of a byte when more bytes wait
	always @*
	begin
		fifo_pop = bit_en && (tx_st == TX_BITS) && !tx_stuff &&
			(tx_cnt == 4'h7) && fifo_m_valid;
	end

	// serialiser: stuff, nrzi, crc16 over bytes after the pid
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_st <= TX_IDLE;
			tx_sr <= 8'h00;
			tx_cnt <= 4'h0;
			tx_ones <= 3'h0;
			tx_bytes <= 2'h0;
			tx_crc <= `ULCD_CRC_INIT;
			tx_crc_on <= 1'b0;
			tx_level <= 1'b1;
			tx_se0 <= 1'b0;
			tx_oe <= 1'b0;
			tx_done <= 1'b0;
		end
		else
		begin
			tx_done <= 1'b0;
			case (tx_st)
			TX_IDLE:
				if (tx_start)
				begin
					tx_st <= TX_BITS;
					tx_sr <= `ULCD_SYNC;
					tx_cnt <= 4'h0;
					tx_ones <= 3'h0;
					tx_bytes <= 2'h0;
					tx_crc <= `ULCD_CRC_INIT;
					tx_crc_on <= 1'b0;
					tx_level <= 1'b1;
					tx_oe <= 1'b1;
				end
			TX_BITS, TX_CRC:
				if (bit_en && tx_stuff)
				begin
					tx_level <= ~tx_level;
					tx_ones <= 3'h0;
				end
				else if (bit_en)
				begin
					// zero toggles, one holds the line
					tx_level <= tx_bit ? tx_level : ~tx_level;
					tx_ones <= tx_bit ? tx_ones + 3'h1 : 3'h0;
					tx_cnt <= tx_cnt + 4'h1;
					if (tx_st == TX_CRC)
						tx_crc <= {tx_crc[14:0], 1'b0};
					else
					begin
						tx_sr <= {1'b0, tx_sr[7:1]};
						if (tx_crc_on)
							tx_crc <= {tx_crc[14:0], 1'b0} ^
								(tx_fb ? `ULCD_CRC_POLY : 16'h0000);
					end
					if (tx_st == TX_CRC && tx_cnt == 4'hf)
					begin
						tx_st <= TX_EOP;
						tx_cnt <= 4'h0;
					end
					else if (tx_st == TX_BITS && tx_cnt == 4'h7)
					begin
						tx_cnt <= 4'h0;
						if (fifo_m_valid)
						begin
							tx_sr <= fifo_m_data;
							tx_crc_on <= (tx_bytes != 2'h0);
							if (tx_bytes != 2'h2)
								tx_bytes <= tx_bytes + 2'h1;
						end
						else
							tx_st <= (tx_bytes == 2'h2) ? TX_CRC : TX_EOP;
					end
				end
			TX_EOP:
				if (bit_en && tx_stuff)
				begin
					// six ones ended the data: stuff before the eop
					tx_level <= ~tx_level;
					tx_ones <= 3'h0;
				end
				else if (bit_en)
				begin
					// two bit times of se0, then one of j, then release
					tx_cnt <= tx_cnt + 4'h1;
					tx_se0 <= (tx_cnt < 4'h2);
					tx_level <= 1'b1;
					if (tx_cnt == 4'h3)
					begin
						tx_st <= TX_IDLE;
						tx_oe <= 1'b0;
						tx_se0 <= 1'b0;
						tx_done <= 1'b1;
					end
				end
			default:
				tx_st <= TX_IDLE;
			endcase
		end
	end

	// receiver: sampled at the bit tick, no phase recovery beyond that
	reg [1:0] rx_st;
	reg [7:0] rx_sr;
	reg [2:0] rx_cnt;
	reg [2:0] rx_ones;
	reg [1:0] rx_bytes;
	reg [7:0] rx_pid;
	reg [15:0] rx_crc;
	reg rx_prev;
	reg rx_done, rx_crc_err, rx_dfn_err, rx_stuff_err, rx_sof;
	wire rx_bit = (dp_l == rx_prev);
	wire rx_on = module_enable_bit & ~tx_oe;
	wire rx_fb = rx_crc[15] ^ rx_bit;
	wire [7:0] rx_byte = {rx_bit, rx_sr[7:1]};
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_st <= RX_HUNT;
			rx_sr <= 8'h00;
			rx_cnt <= 3'h0;
			rx_ones <= 3'h0;
			rx_bytes <= 2'h0;
			rx_pid <= 8'h00;
			rx_crc <= `ULCD_CRC_INIT;
			rx_prev <= 1'b1;
			rx_done <= 1'b0;
			rx_crc_err <= 1'b0;
			rx_dfn_err <= 1'b0;
			rx_stuff_err <= 1'b0;
			rx_sof <= 1'b0;
			rx_data <= 8'h00;
			frame_number_low <= 8'h00;
			frame_number_high <= 8'h00;
		end
		else
		begin
			rx_done <= 1'b0;
			rx_crc_err <= 1'b0;
			rx_dfn_err <= 1'b0;
			rx_stuff_err <= 1'b0;
			rx_sof <= 1'b0;
			if (bit_en)
				rx_prev <= dp_l;
			if (!rx_on)
				rx_st <= RX_HUNT;
			else if (bit_en)
			case (rx_st)
			RX_HUNT:
			begin
				// decoded bits shift in until the sync pattern lines up
				rx_sr <= line_se0 ? 8'h00 : rx_byte;
				rx_cnt <= 3'h0;
				rx_ones <= 3'h1;
				rx_bytes <= 2'h0;
				rx_crc <= `ULCD_CRC_INIT;
				if (!line_se0 && rx_byte == `ULCD_SYNC)
					rx_st <= RX_DATA;
			end
			RX_DATA:
				if (line_se0)
				begin
					rx_st <= RX_WAIT;
					rx_done <= 1'b1;
					rx_dfn_err <= (rx_cnt != 3'h0);
					rx_crc_err <= (rx_bytes == 2'h3) &&
						(rx_crc != `ULCD_CRC_RES);
				end
				else if (rx_ones == 3'h6)
				begin
					// seventh one is a stuffing fault, a zero is dropped
					rx_ones <= 3'h0;
					if (rx_bit)
					begin
						rx_stuff_err <= 1'b1;
						rx_st <= RX_WAIT;
					end
				end
				else
				begin
					rx_ones <= rx_bit ? rx_ones + 3'h1 : 3'h0;
					rx_sr <= rx_byte;
					rx_cnt <= rx_cnt + 3'h1;
					if (rx_bytes != 2'h0)
						rx_crc <= {rx_crc[14:0], 1'b0} ^
							(rx_fb ? `ULCD_CRC_POLY : 16'h0000);
					if (rx_cnt == 3'h7)
					begin
						rx_data <= rx_byte;
						if (rx_bytes != 2'h3)
							rx_bytes <= rx_bytes + 2'h1;
						if (rx_bytes == 2'h0)
							rx_pid <= rx_byte;
						if (rx_bytes == 2'h1 && rx_pid == `ULCD_PID_SOF)
							frame_number_low <= rx_byte;
						if (rx_bytes == 2'h2 && rx_pid == `ULCD_PID_SOF)
						begin
							frame_number_high <= {5'h00, rx_byte[2:0]};
							rx_sof <= 1'b1;
						end
					end
				end
			RX_WAIT:
				if (line_j)
					rx_st <= RX_HUNT;
			default:
				rx_st <= RX_HUNT;
			endcase
		end
	end

	// idle timer restarts on any non-idle line state while enabled
	reg [19:0] idle_cnt;
	reg idle_hit;
	always @(posedge aclk)
	begin
		if (!aresetn || !module_enable_bit || !line_j || tx_oe)
		begin
			idle_cnt <= 20'h00000;
			idle_hit <= 1'b0;
		end
		else
		begin
			idle_hit <= (idle_cnt == IDLE_CYCLES[19:0]);
			if (idle_cnt <= IDLE_CYCLES[19:0])
				idle_cnt <= idle_cnt + 20'h00001;
		end
	end

	// register writes; hardware set beats a write-one clear
	wire [7:0] iflg_set = ({7'h00, idle_hit} << `ULCD_B_IDLE) |
		({7'h00, tx_done | rx_done} << `ULCD_B_TRN) |
		({7'h00, module_enable_bit & ~line_j} << `ULCD_B_ACTV) |
		({7'h00, rx_sof} << `ULCD_B_SOF);
	wire [7:0] eflg_set = ({7'h00, rx_stuff_err} << `ULCD_B_STUFF) |
		({7'h00, rx_dfn_err} << `ULCD_B_DFN8) |
		({7'h00, rx_crc_err} << `ULCD_B_CRC16);
	wire [7:0] iflg_clr = wr_at(`ULCD_A_IFLG) ? wd & `ULCD_M_IFLG : 8'h00;
	wire [7:0] eflg_clr = wr_at(`ULCD_A_EFLG) ? wd & `ULCD_M_EFLG : 8'h00;
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			usb_control <= 8'h00;
			usb_configuration <= 8'h00;
			transfer_status <= 8'h00;
			device_address <= 8'h00;
			usb_interrupt_flags <= 8'h00;
			usb_interrupt_enables <= 8'h00;
			usb_error_flags <= 8'h00;
			usb_error_enables <= 8'h00;
			attach_flag <= 1'b0;
		end
		else
		begin
			if (wr_at(`ULCD_A_CTRL))
				usb_control <= wd & `ULCD_M_CTRL;
			if (wr_at(`ULCD_A_CFG))
				usb_configuration <= wd & `ULCD_M_CFG;
			if (wr_at(`ULCD_A_ADDR))
				device_address <= wd & `ULCD_M_ADDR;
			if (wr_at(`ULCD_A_IEN))
				usb_interrupt_enables <= wd & `ULCD_M_IEN;
			if (wr_at(`ULCD_A_EEN))
				usb_error_enables <= wd & `ULCD_M_EEN;
			// direction bit records whether the last packet was sent
			if (tx_done | rx_done)
				transfer_status <= {5'h00, tx_done, 2'h0};
			usb_interrupt_flags <= (usb_interrupt_flags & ~iflg_clr) |
				iflg_set;
			usb_error_flags <= (usb_error_flags & ~eflg_clr) | eflg_set;
			attach_flag <= (attach_flag &
				~(wr_at(`ULCD_A_LINE) & wd[0])) | attach_set;
		end
	end

	// endpoint control bytes, one per endpoint
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1)
		begin : g_ep
			always @(posedge aclk)
			begin
				if (!aresetn)
					ep_ctrl[gi] <= 8'h00;
				else if (wr_ep && ep_off[4:2] == gi)
					ep_ctrl[gi] <= wd & `ULCD_M_EP;
			end
		end
	endgenerate

	// write response; unmapped offsets answer slverr
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ULCD_RESP_OK;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= map_w ? `ULCD_RESP_OK : `ULCD_RESP_ERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// read side: one registered answer, data held until rready
	wire rd_fire = s_axi_arvalid & ~s_axi_rvalid;
	assign s_axi_arready = rd_fire;
	wire [7:0] ra = s_axi_araddr;
	wire [7:0] ra_ep = ra - `ULCD_A_EP0;
	reg [7:0] rd_val;
	reg rd_ok;
	always @*
	begin
		rd_ok = (ra[1:0] == 2'h0) && (ra <= `ULCD_A_LINE);
		rd_val = 8'h00;
		case (ra)
		`ULCD_A_CTRL: rd_val = usb_control;
		`ULCD_A_CFG: rd_val = usb_configuration;
		`ULCD_A_STAT: rd_val = transfer_status;
		`ULCD_A_ADDR: rd_val = device_address;
		`ULCD_A_FRML: rd_val = frame_number_low;
		`ULCD_A_FRMH: rd_val = frame_number_high;
		`ULCD_A_IFLG: rd_val = usb_interrupt_flags |
			({7'h00, |(usb_error_flags & usb_error_enables)}
			<< `ULCD_B_UERR);
		`ULCD_A_IEN: rd_val = usb_interrupt_enables;
		`ULCD_A_EFLG: rd_val = usb_error_flags;
		`ULCD_A_EEN: rd_val = usb_error_enables;
		`ULCD_A_RXD: rd_val = rx_data;
		`ULCD_A_LINE: rd_val = {5'h00, dm_l, dp_l, attach_flag};
		`ULCD_A_TXCMD: rd_val = {6'h00, fifo_m_valid, tx_oe};
		default:
			if (ra >= `ULCD_A_EP0 && ra <= `ULCD_A_EP7)
				rd_val = ep_ctrl[ra_ep[4:2]];
		endcase
	end
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `ULCD_RESP_OK;
		end
		else if (rd_fire)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_val};
			s_axi_rresp <= rd_ok ? `ULCD_RESP_OK : `ULCD_RESP_ERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule // ulcd_top

//--- bench/ulcd_top_chk_sva.sv
// checker for the line coding block, watching only its top ports
// assumes one aclk domain and a synchronous active low aresetn
`timescale 1ns/1ps
module ulcd_chk #(
	parameter IDLE_CYCLES = 200
) (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire dp_out,
	input wire dp_oe,
	input wire dm_out,
	input wire dm_oe
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// bus answers come one cycle after the taking edge
	chk_write_answer: assert property
		(s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
		else $error("write answer late");
	chk_read_answer: assert property
		(s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_resp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer stays after handshake");
	chk_aw_w_pair: assert property (s_axi_awready == s_axi_wready)
		else $error("address and data taken apart");
	chk_lane_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data outside byte lane");
	// line drive rules
	chk_oe_pair: assert property (dp_oe == dm_oe)
		else $error("data line enables differ");
	chk_no_se1: assert property (dp_oe |-> !(dp_out && dm_out))
		else $error("both data lines driven high");
	chk_eop_j: assert property (
		$fell(dp_oe) |-> $past(dp_out) && !$past(dm_out))
		else $error("driver released outside idle level");
	// a packet starts from the idle j level
	chk_start_j: assert property (
		$rose(dp_oe) |-> dp_out && !dm_out)
		else $error("driver took the line outside idle level");
	// line holds 8 core cycles after each move; bit ticks are 16 or 17 core cycles apart
	chk_bit_time: assert property (
		dp_oe && $changed(dp_out) |=> $stable(dp_out) [*8])
		else $error("line changed faster than the bit rate");
endmodule // ulcd_chk

bind ulcd_top ulcd_chk #(.IDLE_CYCLES(IDLE_CYCLES)) i_ulcd_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.dp_out(dp_out), .dp_oe(dp_oe), .dm_out(dm_out), .dm_oe(dm_oe)
);

//--- bench/ulcd_host.sv
// host end of the cable: decodes device packets, sends packets back
// assumes exact full-speed bit rate; lines idle at j once attached
`timescale 1ns/1ps
module ulcd_host (
	input wire dp_out,
	input wire dp_oe,
	input wire dm_out,
	input wire dm_oe,
	output wire dp_in,
	output wire dm_in
);
	localparam real BIT = 1000.0 / 12.0;
	logic hdp = 1'b1;
	logic hdm = 1'b1;
	logic [7:0] got[$];
	integer n_pkt = 0;
	integer stuff_err = 0;
	real t_ref = 0.0;
	real ts;
	// host drives only while the device has let go of the cable
	assign dp_in = dp_oe ? dp_out : hdp;
	assign dm_in = dm_oe ? dm_out : hdm;
	// sample mid-bit from the first edge; no drift, so no recovery
	always @(posedge dp_oe)
	begin : take
		integer k, ones, nb;
		logic prev, lv;
		logic [7:0] sh;
		@(dp_out);
		t_ref = $realtime;
		prev = 1'b1;
		ones = 0;
		nb = 0;
		sh = 8'h00;
		got.delete();
		for (k = 0; k < 400; k++)
		begin
			#(t_ref + BIT / 2 + k * BIT - $realtime);
			if (!dp_out && !dm_out)
				break;
			lv = dp_out;
			if (ones == 6) // stuffed bit must toggle
			begin
				if (lv == prev)
					stuff_err++;
				ones = 0;
			end
			else
			begin
				sh = {lv == prev, sh[7:1]};
				ones = (lv == prev) ? ones + 1 : 0;
				nb++;
				if (nb % 8 == 0)
					got.push_back(sh);
			end
			prev = lv;
		end
		n_pkt++;
	end
	task hold;
		ts = ts + BIT;
		#(ts - $realtime);
	endtask
	// sync then three bytes lsb first, edges half a bit off device ticks
	task send(input logic [23:0] pk);
		integer k, ones;
		logic [31:0] bits;
		bits = {pk, 8'h80};
		ones = 0;
		ts = t_ref + BIT / 2;
		while (ts < $realtime)
			ts = ts + BIT;
		#(ts - $realtime);
		for (k = 0; k < 32; k++)
		begin
			if (!bits[k])
				{hdp, hdm} = {~hdp, hdp};
			ones = bits[k] ? ones + 1 : 0;
			hold;
			if (ones == 6)
			begin
				{hdp, hdm} = {~hdp, hdp};
				ones = 0;
				hold;
			end
		end
		{hdp, hdm} = 2'h0;
		hold;
		hold;
		{hdp, hdm} = 2'h2;
		hold;
	endtask
endmodule // ulcd_host

//--- bench/ulcd_top_tb.sv
// self-checking bench: register calls over axi4-lite plus host traffic
// assumes the host model on the cable and a short idle count
`timescale 1ns/1ps
module ulcd_top_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	wire awready, wready, bvalid, arready, rvalid;
	wire dp_in, dp_out, dp_oe, dm_in, dm_out, dm_oe;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	integer errors = 0;
	integer n_tests = 0;
	integer i;
	logic [31:0] rd;
	logic [1:0] rs;
	logic [15:0] crc, tail;
	logic [7:0] pk [0:16];
	logic [15:0] regs [0:5] = '{16'h0497, 16'h0c7f, 16'h1c7f, 16'h249f,
		16'h281f, 16'h441f};
	ulcd_top #(.IDLE_CYCLES(200)) i_ulcd_top (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .dp_in(dp_in), .dp_out(dp_out),
		.dp_oe(dp_oe), .dm_in(dm_in), .dm_out(dm_out), .dm_oe(dm_oe)
	);
	ulcd_host i_ulcd_host (.dp_out(dp_out), .dp_oe(dp_oe), .dm_out(dm_out),
		.dm_oe(dm_oe), .dp_in(dp_in), .dm_in(dm_in));
	initial
		forever #2.5 aclk = ~aclk;
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one write; strobes held until taken, bready until the answer
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
		@(posedge aclk);
		while (!awready)
			@(posedge aclk);
		{awvalid, wvalid} <= 2'h0;
		@(posedge aclk);
		while (!bvalid)
			@(posedge aclk);
		rs = bresp;
		bready <= 1'b0;
	endtask
	task rd_reg(input logic [7:0] a);
		@(posedge aclk);
		{araddr, arvalid, rready} <= {a, 2'h3};
		@(posedge aclk);
		while (!arready)
			@(posedge aclk);
		arvalid <= 1'b0;
		@(posedge aclk);
		while (!rvalid)
			@(posedge aclk);
		{rd, rs} = {rdata, rresp};
		rready <= 1'b0;
	endtask
	task report_and_stop;
		$display("comparisons %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// hang guard, well beyond the few thousand cycles expected
	initial
	begin
		#200000;
		errors++;
		report_and_stop;
	end
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		wr(8'h60, 32'hff);
		check(32'(rs), 32'h2);
		rd_reg(8'h60);
		check(rd, 32'h0);
		check(32'(rs), 32'h2);
		// writable bits only stick
		for (i = 0; i < 6; i++)
		begin
			wr(regs[i][15:8], 32'hff);
			rd_reg(regs[i][15:8]);
			check(rd, 32'(regs[i][7:0]));
		end
		wr(8'h54, 32'h1);
		i_ulcd_host.hdm = 1'b0;
		repeat (10) @(posedge aclk);
		rd_reg(8'h54);
		check(rd, 32'h3);
		wr(8'h54, 32'h1);
		wr(8'h00, 32'h8);
		rd_reg(8'h18);
		check(rd & 32'h10, 32'h0);
		repeat (200) @(posedge aclk);
		rd_reg(8'h18);
		check(rd & 32'h10, 32'h10);
		i_ulcd_host.hdm = 1'b1;
		repeat (10) @(posedge aclk);
		i_ulcd_host.hdm = 1'b0;
		repeat (10) @(posedge aclk);
		rd_reg(8'h54);
		check(rd & 32'h1, 32'h0);
		// fifo full before start, last byte pushed while it drains
		for (i = 0; i < 17; i++)
		begin
			pk[i] = (i == 0) ? 8'hc3 : {i[3:0], i[3:0]};
			if (i == 16)
				wr(8'h4c, 32'h1);
			wr(8'h48, 32'(pk[i]));
		end
		while (i_ulcd_host.n_pkt == 0 || dp_oe)
			@(posedge aclk);
		crc = 16'hffff;
		for (i = 8; i < 136; i++)
			crc = {crc[14:0], 1'b0} ^
				((pk[i / 8][i % 8] ^ crc[15]) ? 16'h8005 : 16'h0);
		tail = {<<{~crc}};
		check(i_ulcd_host.got.size(), 20);
		check(32'(i_ulcd_host.got[0]), 32'h80);
		for (i = 1; i < 18; i++)
			check(32'(i_ulcd_host.got[i]), 32'(pk[i - 1]));
		check({i_ulcd_host.got[19], i_ulcd_host.got[18]}, 32'(tail));
		check(i_ulcd_host.stuff_err, 0);
		rd_reg(8'h08);
		check(rd & 32'h4, 32'h4);
		rd_reg(8'h4c);
		check(rd & 32'h3, 32'h0);
		// frame number ff forces a stuffed bit on receive
		i_ulcd_host.send(24'h05ffa5);
		repeat (20) @(posedge aclk);
		rd_reg(8'h10);
		check(rd, 32'hff);
		rd_reg(8'h14);
		check(rd, 32'h5);
		rd_reg(8'h18);
		check(rd & 32'h48, 32'h48);
		rd_reg(8'h08);
		check(rd & 32'h4, 32'h0);
		report_and_stop;
	end
endmodule // ulcd_top_tb
